// ===== logic/led_cur_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: ref_clk at 200 MHz
// Notes: definitions only
`ifndef LED_CUR_CFG_SVH
`define LED_CUR_CFG_SVH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define ADDR_FLASH_CH2 8'h02
`define ADDR_TORCH_PAIR 8'h03
`define ADDR_INDICATOR 8'h05
`define REG_RESET 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FLASH_LVL_MSB 7
`define FLASH_LVL_LSB 3
`define TORCH1_MSB 6
`define TORCH1_LSB 4
`define TORCH2_MSB 2
`define TORCH2_LSB 0
`define BLINK_BIT 6
`define RAMP_BIT 5
`define LAMP_LVL_MSB 4
`define LAMP_LVL_LSB 0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define ON_BASE_MS 128
`define OFF_BASE_MS 512
`define RAMP_BASE_MS 128
`define RAMP_STEP_SHIFT 5

`endif

// ===== logic/led_cur_pkg.sv
// Purpose: shared types of the current-setting bank
// Assumes: nothing
// Notes: numbers live in led_cur_cfg.svh
package led_cur_pkg;

  // register port request and answer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } reg_rsp_t;

  // fields of the separate lamp timing register
  typedef struct packed {
    logic [1:0] off_time;
    logic [1:0] on_time;
    logic [1:0] rise_time;
    logic [1:0] fall_time;
  } lamp_timing_t;

  typedef enum logic [1:0] {
    LAMP_DARK = 2'b00,
    LAMP_RISE = 2'b01,
    LAMP_LIT = 2'b10,
    LAMP_FALL = 2'b11
  } lamp_state_t;

endpackage

// ===== logic/lamp_sequencer.sv
// Purpose: blink and ramp sequencing of the status lamp current
// Assumes: lamp_request, codes and timing synchronous to ref_clk
// Notes: all decisions are taken on a 1 ms enable pulse
`include "led_cur_cfg.svh"

module lamp_sequencer
  import led_cur_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic lamp_request,
  input wire logic blink_enable,
  input wire logic ramp_enable,
  input wire logic [4:0] level_code,
  input wire lamp_timing_t timing,
  output logic [5:0] drive_level,
  output logic lit
);

  localparam int unsigned DIV_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic tick, next_tick;
  lamp_state_t state, next_state;
  logic [12:0] ms_cnt, next_ms_cnt;
  logic [5:0] step_cnt, next_step_cnt;
  logic [5:0] next_drive_level;
  logic next_lit;
  logic [5:0] target;
  logic [12:0] on_ms, off_ms;
  logic [5:0] rise_step, fall_step;

  // 0.5 mA units: code plus one, so code 0 is still lit
  assign target = {1'b0, level_code} + 6'h01;
  assign on_ms = 13'(`ON_BASE_MS) << timing.on_time;
  assign off_ms = 13'(`OFF_BASE_MS) << timing.off_time;
  assign rise_step = 6'(`RAMP_BASE_MS >> `RAMP_STEP_SHIFT) << timing.rise_time;
  assign fall_step = 6'(`RAMP_BASE_MS >> `RAMP_STEP_SHIFT) << timing.fall_time;

  // millisecond enable divider
  always_comb begin
    next_tick = (div_cnt == DIV_W'(MS_CYCLES - 1));
    next_div_cnt = next_tick ? '0 : div_cnt + 1'b1;
  end

  // sequencer; changes wait for the next tick, so up to 1 ms latency
  always_comb begin
    next_state = state;
    next_ms_cnt = ms_cnt;
    next_step_cnt = step_cnt;
    next_drive_level = drive_level;
    if (tick) begin
      unique case (state)
        LAMP_DARK: begin
          next_drive_level = '0;
          // (RULE_11) off interval wait
          if (!lamp_request) begin
            next_ms_cnt = off_ms;
          end else if (!blink_enable || ms_cnt >= off_ms - 13'h0001) begin
            next_state = LAMP_RISE;
            next_step_cnt = '0;
          end else begin
            next_ms_cnt = ms_cnt + 13'h0001;
          end
        end
        LAMP_RISE: begin
          // (RULE_12) stepped ramp up
          if (!lamp_request) begin
            next_state = LAMP_FALL;
          end else if (!ramp_enable || drive_level >= target) begin
            next_drive_level = target;
            next_state = LAMP_LIT;
            next_ms_cnt = '0;
          end else if (step_cnt >= rise_step - 6'h01) begin
            next_drive_level = drive_level + 6'h01;
            next_step_cnt = '0;
          end else begin
            next_step_cnt = step_cnt + 6'h01;
          end
        end
        LAMP_LIT: begin
          next_drive_level = target;
          // (RULE_11) on interval end
          if (!lamp_request || (blink_enable && ms_cnt >= on_ms - 13'h0001)) begin
            next_state = LAMP_FALL;
            next_step_cnt = '0;
          end else begin
            next_ms_cnt = ms_cnt + 13'h0001;
          end
        end
        LAMP_FALL: begin
          // (RULE_12) stepped ramp down
          if (!ramp_enable || drive_level == 6'h00) begin
            next_drive_level = '0;
            next_state = LAMP_DARK;
            next_ms_cnt = '0;
          end else if (step_cnt >= fall_step - 6'h01) begin
            next_drive_level = drive_level - 6'h01;
            next_step_cnt = '0;
          end else begin
            next_step_cnt = step_cnt + 6'h01;
          end
        end
      endcase
    end
    next_lit = (next_state == LAMP_LIT);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= '0;
      tick <= 1'b0;
      state <= LAMP_DARK;
      ms_cnt <= '0;
      step_cnt <= '0;
      drive_level <= '0;
      lit <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      state <= next_state;
      ms_cnt <= next_ms_cnt;
      step_cnt <= next_step_cnt;
      drive_level <= next_drive_level;
      lit <= next_lit;
    end
  end

  a_dark_is_off: assert property (@(posedge ref_clk) disable iff (!resetn) // (RULE_11)
    (state == LAMP_DARK) |-> (drive_level == 6'h00))
    else $error("lamp driven while dark");

  a_no_ramp_jump: assert property (@(posedge ref_clk) disable iff (!resetn) // (RULE_12)
    (tick && state == LAMP_RISE && lamp_request && !ramp_enable)
    |=> (drive_level == $past(target)))
    else $error("lamp did not jump with ramp off");

endmodule

// ===== logic/led_current_setting_regs.sv
// Purpose: flash, torch and status lamp current-setting registers
// Assumes: register port and lamp inputs synchronous to ref_clk
// Notes: one read answer per read strobe, one cycle later

`include "led_cur_cfg.svh"

// Summary of operation
// (RULE_01) flash channel two register at 0x02
// (RULE_02) bits 7:3 pick flash current code
// (RULE_03) reserved bits carry no function
// (RULE_04) torch pair register at 0x03
// (RULE_05) bits 6:4 pick channel one torch
// (RULE_06) bits 2:0 pick channel two torch
// (RULE_07) status lamp register at 0x05
// (RULE_08) bit 6 enables lamp blinking
// (RULE_09) bit 5 enables lamp ramping
// (RULE_10) bits 4:0 pick lamp current
// (RULE_11) blink alternates timed on and off
// (RULE_12) ramps follow timed rise and fall
// (RULE_13) reads return fields, reserved as zero
// (RULE_14) lamp current is half mA times code+1
module led_current_setting_regs
  import led_cur_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire reg_req_t reg_req,
  input wire logic lamp_request,
  input wire lamp_timing_t lamp_timing_register,
  output reg_rsp_t reg_rsp,
  output logic [4:0] ch2_flash_level,
  output logic [2:0] ch1_torch_level,
  output logic [2:0] ch2_torch_level,
  output logic lamp_blink_enable,
  output logic lamp_ramp_enable,
  output logic [4:0] lamp_current_level,
  output logic [5:0] lamp_drive_level,
  output logic lamp_lit
);

  // ----------------------------------------
  // register fields
  // ----------------------------------------
  logic [4:0] next_ch2_flash_level;
  logic [2:0] next_ch1_torch_level;
  logic [2:0] next_ch2_torch_level;
  logic next_lamp_blink_enable;
  logic next_lamp_ramp_enable;
  logic [4:0] next_lamp_current_level;
  reg_rsp_t next_reg_rsp;
  logic [7:0] read_word;
  logic addr_mapped;

  // field updates; reserved bits of wdata are simply not stored
  always_comb begin
    next_ch2_flash_level = ch2_flash_level;
    next_ch1_torch_level = ch1_torch_level;
    next_ch2_torch_level = ch2_torch_level;
    next_lamp_blink_enable = lamp_blink_enable;
    next_lamp_ramp_enable = lamp_ramp_enable;
    next_lamp_current_level = lamp_current_level;
    if (reg_req.wr) begin
      case (reg_req.addr)
        // (RULE_01) flash code store
        `ADDR_FLASH_CH2: begin
          // (RULE_02) flash code field
          next_ch2_flash_level = reg_req.wdata[`FLASH_LVL_MSB:`FLASH_LVL_LSB];
        end
        // (RULE_04) torch pair store
        `ADDR_TORCH_PAIR: begin
          // (RULE_05) channel one torch
          next_ch1_torch_level = reg_req.wdata[`TORCH1_MSB:`TORCH1_LSB];
          // (RULE_06) channel two torch
          next_ch2_torch_level = reg_req.wdata[`TORCH2_MSB:`TORCH2_LSB];
        end
        // (RULE_07) lamp register store
        `ADDR_INDICATOR: begin
          // (RULE_08) blink enable bit
          next_lamp_blink_enable = reg_req.wdata[`BLINK_BIT];
          // (RULE_09) ramp enable bit
          next_lamp_ramp_enable = reg_req.wdata[`RAMP_BIT];
          // (RULE_10) lamp current code
          next_lamp_current_level = reg_req.wdata[`LAMP_LVL_MSB:`LAMP_LVL_LSB];
        end
        default: begin
          // unmapped offsets: writes are dropped
        end
      endcase
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------

  // (RULE_13) fields back, reserved zero
  always_comb begin
    read_word = `REG_RESET;
    addr_mapped = 1'b1;
    case (reg_req.addr)
      `ADDR_FLASH_CH2: begin
        // (RULE_03) bits 2:0 read as zero
        read_word[`FLASH_LVL_MSB:`FLASH_LVL_LSB] = ch2_flash_level;
      end
      `ADDR_TORCH_PAIR: begin
        read_word[`TORCH1_MSB:`TORCH1_LSB] = ch1_torch_level;
        read_word[`TORCH2_MSB:`TORCH2_LSB] = ch2_torch_level;
      end
      `ADDR_INDICATOR: begin
        read_word[`BLINK_BIT] = lamp_blink_enable;
        read_word[`RAMP_BIT] = lamp_ramp_enable;
        read_word[`LAMP_LVL_MSB:`LAMP_LVL_LSB] = lamp_current_level;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  end

  // answer is registered so the host sees a clean one-cycle strobe;
  // a read in the same cycle as a write returns the old value
  always_comb begin
    next_reg_rsp.valid = reg_req.rd;
    next_reg_rsp.data = reg_req.rd ? read_word : `REG_RESET;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ch2_flash_level <= '0;
      ch1_torch_level <= '0;
      ch2_torch_level <= '0;
      lamp_blink_enable <= 1'b0;
      lamp_ramp_enable <= 1'b0;
      lamp_current_level <= '0;
      reg_rsp <= '0;
    end else begin
      ch2_flash_level <= next_ch2_flash_level;
      ch1_torch_level <= next_ch1_torch_level;
      ch2_torch_level <= next_ch2_torch_level;
      lamp_blink_enable <= next_lamp_blink_enable;
      lamp_ramp_enable <= next_lamp_ramp_enable;
      lamp_current_level <= next_lamp_current_level;
      reg_rsp <= next_reg_rsp;
    end
  end

  // ----------------------------------------
  // status lamp sequencing
  // ----------------------------------------

  // (RULE_14) drive level is code plus one
  lamp_sequencer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_lamp_sequencer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .lamp_request(lamp_request),
    .blink_enable(lamp_blink_enable),
    .ramp_enable(lamp_ramp_enable),
    .level_code(lamp_current_level),
    .timing(lamp_timing_register),
    .drive_level(lamp_drive_level),
    .lit(lamp_lit)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_flash_write_store: assert property ( // (RULE_01)
    (reg_req.wr && reg_req.addr == `ADDR_FLASH_CH2)
    |=> (ch2_flash_level == $past(reg_req.wdata[`FLASH_LVL_MSB:`FLASH_LVL_LSB])))
    else $error("flash code not stored");

  a_flash_hold_other: assert property ( // (RULE_02)
    !(reg_req.wr && reg_req.addr == `ADDR_FLASH_CH2) |=> $stable(ch2_flash_level))
    else $error("flash code changed without write");

  a_torch1_store: assert property ( // (RULE_05)
    (reg_req.wr && reg_req.addr == `ADDR_TORCH_PAIR)
    |=> (ch1_torch_level == $past(reg_req.wdata[`TORCH1_MSB:`TORCH1_LSB])))
    else $error("torch one code not stored");

  a_torch2_store: assert property ( // (RULE_06)
    (reg_req.wr && reg_req.addr == `ADDR_TORCH_PAIR)
    |=> (ch2_torch_level == $past(reg_req.wdata[`TORCH2_MSB:`TORCH2_LSB])))
    else $error("torch two code not stored");

  a_torch_hold_other: assert property ( // (RULE_04)
    !(reg_req.wr && reg_req.addr == `ADDR_TORCH_PAIR)
    |=> ($stable(ch1_torch_level) && $stable(ch2_torch_level)))
    else $error("torch codes changed without write");

  a_lamp_fields_store: assert property ( // (RULE_07)
    (reg_req.wr && reg_req.addr == `ADDR_INDICATOR)
    |=> (lamp_current_level == $past(reg_req.wdata[`LAMP_LVL_MSB:`LAMP_LVL_LSB])
         && lamp_blink_enable == $past(reg_req.wdata[`BLINK_BIT])
         && lamp_ramp_enable == $past(reg_req.wdata[`RAMP_BIT])))
    else $error("lamp fields not stored");

  a_blink_off_steady: assert property ( // (RULE_08)
    (!lamp_blink_enable && lamp_request && lamp_lit)
    ##1 (!lamp_blink_enable && lamp_request) |-> lamp_lit)
    else $error("lamp blinked with blink disabled");

  a_read_answer_next: assert property ( // (RULE_13)
    reg_req.rd |=> (reg_rsp.valid && reg_rsp.data == $past(read_word)))
    else $error("read answer missing or wrong");

  a_read_single_pulse: assert property ( // (RULE_13)
    !reg_req.rd |=> !reg_rsp.valid)
    else $error("answer without read");

  a_flash_rsvd_zero: assert property ( // (RULE_03)
    (reg_req.rd && reg_req.addr == `ADDR_FLASH_CH2)
    |=> (reg_rsp.data[`FLASH_LVL_LSB-1:0] == 3'h0))
    else $error("reserved flash bits read nonzero");

  a_torch_rsvd_zero: assert property ( // (RULE_03)
    (reg_req.rd && reg_req.addr == `ADDR_TORCH_PAIR)
    |=> (!reg_rsp.data[7] && !reg_rsp.data[3]))
    else $error("reserved torch bits read nonzero");

  a_unmapped_zero: assert property ( // (RULE_13)
    (reg_req.rd && !addr_mapped) |=> (reg_rsp.data == 8'h00))
    else $error("unmapped read nonzero");

  a_lamp_rsvd_zero: assert property ( // (RULE_03)
    (reg_req.rd && reg_req.addr == `ADDR_INDICATOR) |=> !reg_rsp.data[7])
    else $error("reserved lamp bit read nonzero");

  // read-back checks look at the answer pins, not at read_word, so a wrong mux shows
  a_flash_read_back: assert property ( // (RULE_01)
    (reg_req.rd && reg_req.addr == `ADDR_FLASH_CH2)
    |=> (reg_rsp.data[`FLASH_LVL_MSB:`FLASH_LVL_LSB] == $past(ch2_flash_level)))
    else $error("flash code read back wrong");

  a_torch_read_back: assert property ( // (RULE_04)
    (reg_req.rd && reg_req.addr == `ADDR_TORCH_PAIR)
    |=> (reg_rsp.data[`TORCH1_MSB:`TORCH1_LSB] == $past(ch1_torch_level)
         && reg_rsp.data[`TORCH2_MSB:`TORCH2_LSB] == $past(ch2_torch_level)))
    else $error("torch codes read back wrong");

  a_lamp_read_back: assert property ( // (RULE_07)
    (reg_req.rd && reg_req.addr == `ADDR_INDICATOR)
    |=> (reg_rsp.data[`LAMP_LVL_MSB:`LAMP_LVL_LSB] == $past(lamp_current_level)
         && reg_rsp.data[`BLINK_BIT] == $past(lamp_blink_enable)
         && reg_rsp.data[`RAMP_BIT] == $past(lamp_ramp_enable)))
    else $error("lamp fields read back wrong");

  a_lamp_hold_other: assert property ( // (RULE_07)
    !(reg_req.wr && reg_req.addr == `ADDR_INDICATOR)
    |=> ($stable(lamp_current_level) && $stable(lamp_blink_enable)
         && $stable(lamp_ramp_enable)))
    else $error("lamp fields changed without write");

  // a write to a hole in the map must leave the flash, torch and lamp level fields alone
  a_unmapped_write_drop: assert property ( // (RULE_13)
    (reg_req.wr && reg_req.addr != `ADDR_FLASH_CH2 && reg_req.addr != `ADDR_TORCH_PAIR
     && reg_req.addr != `ADDR_INDICATOR)
    |=> ($stable(ch2_flash_level) && $stable(ch1_torch_level) && $stable(ch2_torch_level)
         && $stable(lamp_current_level)))
    else $error("unmapped write changed a field");

  a_rsp_idle_zero: assert property ( // (RULE_13)
    !reg_rsp.valid |-> (reg_rsp.data == 8'h00))
    else $error("answer data without valid");

  a_drive_in_range: assert property ( // (RULE_14)
    lamp_drive_level <= 6'h20)
    else $error("lamp drive above full scale");

  a_lit_means_driven: assert property ( // (RULE_10)
    lamp_lit |-> (lamp_drive_level != 6'h00))
    else $error("lamp lit with no current");

  a_lamp_level_math: assert property ( // (RULE_10)
    $rose(lamp_lit) |-> (lamp_drive_level == {1'b0, lamp_current_level} + 6'h01))
    else $error("lamp level not code plus one");

  a_lamp_ramp_bound: assert property ( // (RULE_09)
    (lamp_ramp_enable && !lamp_lit && $changed(lamp_drive_level))
    |-> ((lamp_drive_level - $past(lamp_drive_level) == 6'h01)
         || ($past(lamp_drive_level) - lamp_drive_level == 6'h01)))
    else $error("ramp moved more than one step");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_flash_write: cover property (
    reg_req.wr && reg_req.addr == `ADDR_FLASH_CH2 && reg_req.wdata == 8'hFF);

  c_lamp_read: cover property (
    reg_req.rd && reg_req.addr == `ADDR_INDICATOR ##1 reg_rsp.data != 8'h00);

  c_lamp_blink_cycle: cover property (
    lamp_blink_enable && lamp_request && $fell(lamp_lit));

  c_lamp_ramped_on: cover property (
    lamp_ramp_enable && $rose(lamp_lit));

  c_torch_write: cover property (
    reg_req.wr && reg_req.addr == `ADDR_TORCH_PAIR);

endmodule

// ===== verif/reg_host_model.sv
// Purpose: host side of the current-setting register port
// Assumes: requests launched on the falling edge of ref_clk
// Notes: reserved bits are cleared unless a raw write is asked for
`include "led_cur_cfg.svh"

module reg_host_model
  import led_cur_pkg::*;
(
  input wire logic ref_clk,
  output reg_req_t reg_req,
  input wire reg_rsp_t reg_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet port at time zero
  initial begin
    reg_req = '0;
  end

  // one write, strobe left up so back-to-back accesses need no gap
  task automatic write(input logic [7:0] addr, input logic [7:0] data, input bit raw);
    logic [7:0] keep;
    keep = 8'hFF;
    if (!raw) begin
      case (addr)
        `ADDR_FLASH_CH2: keep = 8'hF8;
        `ADDR_TORCH_PAIR: keep = 8'h77;
        `ADDR_INDICATOR: keep = 8'h7F;
        default: keep = 8'hFF;
      endcase
    end
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data & keep};
  endtask

  // released address and data lines show a changed pattern, never the last value
  task automatic idle();
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
  endtask

  // answer lands on the taking edge itself and stands one cycle only,
  // so it is taken at the very next falling edge, mid-way through that cycle
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~reg_req.wdata};
    idle();
    valid = reg_rsp.valid;
    data = reg_rsp.data;
  endtask
endmodule

// ===== verif/testbench.sv
// Purpose: self-checking bench of the current-setting register bank
// Assumes: MS_CYCLES shortened to 4 so one ms tick is 4 cycles
// Notes: expected values come from a shadow copy of the registers
`include "led_cur_cfg.svh"

module testbench
  import led_cur_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned MS = 4;
  localparam logic [7:0] MAP [3] = '{`ADDR_FLASH_CH2, `ADDR_TORCH_PAIR, `ADDR_INDICATOR};

  logic ref_clk;
  logic resetn;
  logic lamp_request;
  lamp_timing_t lamp_timing;
  reg_req_t reg_req;
  reg_rsp_t reg_rsp;
  logic [4:0] ch2_flash_level;
  logic [2:0] ch1_torch_level;
  logic [2:0] ch2_torch_level;
  logic lamp_blink_enable;
  logic lamp_ramp_enable;
  logic [4:0] lamp_current_level;
  logic [5:0] lamp_drive_level;
  logic lamp_lit;
  int errors;
  int checks;
  logic [7:0] shadow [8];

  led_current_setting_regs #(.MS_CYCLES(MS)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req), .lamp_request(lamp_request),
    .lamp_timing_register(lamp_timing), .reg_rsp(reg_rsp), .ch2_flash_level(ch2_flash_level),
    .ch1_torch_level(ch1_torch_level), .ch2_torch_level(ch2_torch_level),
    .lamp_blink_enable(lamp_blink_enable), .lamp_ramp_enable(lamp_ramp_enable),
    .lamp_current_level(lamp_current_level), .lamp_drive_level(lamp_drive_level),
    .lamp_lit(lamp_lit)
  );

  reg_host_model u_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));

  // ----------------------------------------
  // clock, expectations and checks
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // bits that survive a write, zero for unmapped offsets
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      `ADDR_FLASH_CH2: return 8'hF8;
      `ADDR_TORCH_PAIR: return 8'h77;
      `ADDR_INDICATOR: return 8'h7F;
      default: return 8'h00;
    endcase
  endfunction

  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_fields();
    cmp("flash_ch2_current", shadow[2], {ch2_flash_level, 3'b000});
    cmp("torch_current_pair", shadow[3], {1'b0, ch1_torch_level, 1'b0, ch2_torch_level});
    cmp("indicator_current", shadow[5], {1'b0, lamp_blink_enable, lamp_ramp_enable,
      lamp_current_level});
  endtask

  task automatic check_reg(input logic [7:0] a);
    logic [7:0] d;
    logic v;
    u_host.read(a, d, v);
    cmp("rsp_valid", 8'h01, {7'b0, v});
    cmp("read_data", shadow[a[2:0]] & keep_mask(a), d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
    u_host.write(a, d, raw);
    u_host.idle();
    @(negedge ref_clk);
    shadow[a[2:0]] = d & keep_mask(a);
  endtask

  // bounded wait: 0 lamp not lit, 1 lamp lit, 2 drive level off
  task automatic wait_for(input int sel, input int bound, output int n);
    n = 0;
    while (!((sel == 0 && lamp_lit === 1'b0) || (sel == 1 && lamp_lit === 1'b1) ||
             (sel == 2 && lamp_drive_level === 6'h00))) begin
      @(negedge ref_clk);
      n++;
      if (n > bound) begin
        errors++;
        $display("[ERR] lamp wait %0d expected within %0d seen timeout", sel, bound);
        summarize();
      end
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    int n;
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    lamp_request = 1'b0;
    lamp_timing = '0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    void'($urandom(32'h7a36));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    // reset values of all three registers
    foreach (MAP[i]) check_reg(MAP[i]);
    check_fields();
    // raw writes of ones, and a5 to 0x07: reserved bits dropped, unmapped ignored
    foreach (MAP[i]) begin
      wr(MAP[i], 8'hFF, 1'b1);
      check_reg(MAP[i]);
    end
    wr(8'h04, 8'hFF, 1'b1);
    check_reg(8'h04);
    wr(8'h07, 8'hA5, 1'b1);
    check_reg(8'h07);
    check_fields();
    // every code of every field
    for (int c = 0; c < 32; c++) begin
      wr(8'h02, {c[4:0], 3'b000}, 1'b0);
      wr(8'h03, {1'b0, c[2:0], 1'b0, ~c[2:0]}, 1'b0);
      wr(8'h05, {1'b0, c[1:0], c[4:0]}, 1'b0);
      check_fields();
    end
    // random back-to-back writes, some read straight after
    repeat (40) begin
      a = MAP[$urandom_range(2, 0)];
      d = 8'($urandom);
      u_host.write(a, d, 1'b0);
      shadow[a[2:0]] = d & keep_mask(a);
      if ($urandom_range(1, 0) == 1) begin
        check_reg(a);
        check_fields();
      end
    end
    u_host.idle();
    @(negedge ref_clk);
    check_fields();
    // steady lamp, no ramp, no blink: level is code plus one
    wr(8'h05, 8'h03, 1'b0);
    lamp_request = 1'b1;
    wait_for(1, 40, n);
    cmp("lamp_drive_level", 8'd4, {2'b00, lamp_drive_level});
    lamp_request = 1'b0;
    wait_for(2, 40, n);
    // let two ticks pass dark with the request low, so the restart skips the off wait
    repeat (2 * MS) @(negedge ref_clk);
    // blink: 256 ms on, 512 ms off at 4 cycles a ms
    lamp_timing = '{off_time: 2'b00, on_time: 2'b01, rise_time: 2'b00, fall_time: 2'b00};
    wr(8'h05, 8'h45, 1'b0);
    lamp_request = 1'b1;
    wait_for(1, 40, n);
    wait_for(0, 1100, n);
    cmp("on_interval_ok", 8'h01, {7'b0, n >= 1016 && n <= 1036});
    wait_for(1, 2200, n);
    cmp("off_interval_ok", 8'h01, {7'b0, n >= 2040 && n <= 2068});
    lamp_request = 1'b0;
    wait_for(2, 40, n);
    // ramp of full code: 32 steps of 4 ms each way
    wr(8'h05, 8'h3F, 1'b0);
    lamp_request = 1'b1;
    wait_for(1, 700, n);
    cmp("rise_time_ok", 8'h01, {7'b0, n >= 480 && n <= 540});
    cmp("lamp_drive_level", 8'd32, {2'b00, lamp_drive_level});
    lamp_request = 1'b0;
    wait_for(2, 700, n);
    cmp("fall_time_ok", 8'h01, {7'b0, n >= 480 && n <= 540});
    // second reset in mid-run: every field must drop back to zero
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    foreach (shadow[i]) shadow[i] = 8'h00;
    foreach (MAP[i]) check_reg(MAP[i]);
    check_fields();
    summarize();
  end
endmodule
